// >>> wdg_pkg.sv
// Package for the watchdog downcounter: bus map, bit positions and timing.
// Assumes a 200 MHz core clock and an 8 MHz prescaler-equivalent timebase.
package wdg_pkg;
	localparam logic [1:0] ADDR_CTRL      = 2'h0;
	localparam logic [1:0] ADDR_OPTIONS   = 2'h1;
	localparam logic [1:0] ADDR_STATUS    = 2'h2;
	localparam int         ACT_BIT        = 7;
	localparam int         GUARD_BIT      = 6;
	localparam logic [7:0] CTRL_RESET     = 8'h7F;
	localparam int         CLK_MHZ        = 200;
	localparam int         CPU_MHZ        = 8;
	localparam int         PRESCALE_CPU   = 16384;
	localparam int         PRESCALE_CYC   = PRESCALE_CPU * CLK_MHZ / CPU_MHZ;
	localparam int         RST_PHASE_SHORT = 256;
	localparam int         RST_PHASE_LONG  = 4096;
	localparam int         RST_SHORT_CYC  = RST_PHASE_SHORT * CLK_MHZ / CPU_MHZ;
	localparam int         RST_LONG_CYC   = RST_PHASE_LONG * CLK_MHZ / CPU_MHZ;
endpackage : wdg_pkg

// >>> watchdog_downcounter.sv
// Watchdog downcounter with sticky activation and reset-phase generator.
// Assumes a single clock, synchronous strobes and a system reset fed back from wdg_reset.
`timescale 1ns/1ps
`default_nettype none

module watchdog_downcounter
	import wdg_pkg::*;
#(
	parameter int PRESCALE = PRESCALE_CYC,
	parameter int PHASE_SHORT = RST_SHORT_CYC,
	parameter int PHASE_LONG  = RST_LONG_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       hw_watchdog_opt,
	input  wire logic       halt_req,
	output logic            halt_grant,
	output logic            wdg_reset
);
	logic [7:0]  ctrl_r;
	logic        active_r;
	logic        halt_reset_option_r;
	logic        long_phase_r;
	logic        hw_opt_r;
	logic [23:0] pre_r;
	logic        tick;
	logic [7:0]  ctrl_nxt;
	logic        trip;
	logic [19:0] phase_r;
	logic        cause_r;
	logic        halt_grant_r;

	logic wr_ctrl;
	assign wr_ctrl = wr && (addr == ADDR_CTRL);

	// free prescaler
	// Never cleared by writes, so refresh timing has one-period jitter
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pre_r <= '0;
		else if (pre_r == 24'(PRESCALE - 1))
			pre_r <= '0;
		else
			pre_r <= pre_r + 24'h000001;
	end
	assign tick = (pre_r == 24'(PRESCALE - 1));

	// Strap resampled on every clock, during reset too; the flop has no reset
	always_ff @(posedge clk) begin
		hw_opt_r <= hw_watchdog_opt;
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (tick)
			ctrl_nxt[GUARD_BIT:0] = ctrl_r[GUARD_BIT:0] - 7'h01;
		if (wr_ctrl)
			ctrl_nxt[GUARD_BIT:0] = wdata[GUARD_BIT:0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ctrl_r <= CTRL_RESET;
		else
			ctrl_r <= ctrl_nxt;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			active_r <= 1'b0;
		else if (hw_opt_r || (wr_ctrl && wdata[ACT_BIT]))
			active_r <= 1'b1;
	end

	logic act_now;
	assign act_now = active_r || hw_opt_r || (wr_ctrl && wdata[ACT_BIT]);

	// Options register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			halt_reset_option_r <= 1'b1;
			long_phase_r        <= 1'b0;
		end else if (wr && addr == ADDR_OPTIONS) begin
			halt_reset_option_r <= wdata[0];
			long_phase_r        <= wdata[1];
		end
	end

	assign trip = act_now && (
		(ctrl_r[GUARD_BIT] && !ctrl_nxt[GUARD_BIT]) ||
		(wr_ctrl && !wdata[GUARD_BIT]) ||
		(halt_req && halt_reset_option_r));

	// reset phase
	// Phase counter clears on its own expiry and on rst; rst feeds back from wdg_reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_r <= '0;
			cause_r <= 1'b0;
		end else if (phase_r != 20'h00000) begin
			phase_r <= phase_r - 20'h00001;
		end else if (trip) begin
			phase_r <= long_phase_r ? 20'(PHASE_LONG) : 20'(PHASE_SHORT);
			cause_r <= 1'b1;
		end
	end
	assign wdg_reset = (phase_r != 20'h00000);

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			halt_grant_r <= 1'b0;
		else
			halt_grant_r <= halt_req && !(act_now && halt_reset_option_r);
	end
	assign halt_grant = halt_grant_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (rd) begin
			case (addr)
				ADDR_CTRL:    rdata <= {active_r | hw_opt_r, ctrl_r[GUARD_BIT:0]};
				ADDR_OPTIONS: rdata <= {6'h00, long_phase_r, halt_reset_option_r};
				ADDR_STATUS:  rdata <= {6'h00, hw_opt_r, cause_r};
				default:      rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

	property p_sticky;
		@(posedge clk) disable iff (rst)
			active_r |=> active_r;
	endproperty
	a_sticky: assert property (p_sticky) else $error("activation dropped");

	property p_activate;
		@(posedge clk) disable iff (rst)
			(wr_ctrl && wdata[ACT_BIT]) |=> active_r;
	endproperty
	a_activate: assert property (p_activate) else $error("activate ignored");

	property p_swreset;
		@(posedge clk) disable iff (rst)
			(wr_ctrl && wdata[ACT_BIT] && !wdata[GUARD_BIT] && !wdg_reset) |=> wdg_reset;
	endproperty
	a_swreset: assert property (p_swreset) else $error("no software reset");

	property p_halt;
		@(posedge clk) disable iff (rst)
			(halt_req && act_now && halt_reset_option_r) |=> !halt_grant;
	endproperty
	a_halt: assert property (p_halt) else $error("halt granted while armed");

	property p_halt_ok;
		@(posedge clk) disable iff (rst)
			(halt_req && !act_now) |=> halt_grant;
	endproperty
	a_halt_ok: assert property (p_halt_ok) else $error("halt refused");

	property p_count;
		@(posedge clk) disable iff (rst)
			(tick && !wr_ctrl) |=> ctrl_r[GUARD_BIT:0] == $past(ctrl_r[GUARD_BIT:0]) - 7'h01;
	endproperty
	a_count: assert property (p_count) else $error("counter did not step");

	property p_inactive_quiet;
		@(posedge clk) disable iff (rst)
			(!act_now && !wdg_reset) |=> !wdg_reset;
	endproperty
	a_inactive_quiet: assert property (p_inactive_quiet) else $error("reset while inactive");

	property p_phase;
		@(posedge clk) disable iff (rst)
			$rose(wdg_reset) |-> wdg_reset [*4];
	endproperty
	a_phase: assert property (p_phase) else $error("reset phase short");

	property p_pre_wrap;
		@(posedge clk) disable iff (rst)
			tick |=> pre_r == 24'h000000;
	endproperty
	a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler did not wrap");

	property p_tick_single;
		@(posedge clk) disable iff (rst)
			tick |=> !tick;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("double tick");

	property p_pre_write;
		@(posedge clk) disable iff (rst)
			(wr_ctrl && !tick) |=> pre_r == $past(pre_r) + 24'h000001;
	endproperty
	a_pre_write: assert property (p_pre_write) else $error("prescaler disturbed by write");

	property p_write_load;
		@(posedge clk) disable iff (rst)
			wr_ctrl |=> ctrl_r[GUARD_BIT:0] == $past(wdata[GUARD_BIT:0]);
	endproperty
	a_write_load: assert property (p_write_load) else $error("count not loaded");

	property p_wrap;
		@(posedge clk) disable iff (rst)
			(tick && !wr_ctrl && ctrl_r[GUARD_BIT:0] == 7'h00) |=> ctrl_r[GUARD_BIT:0] == 7'h7F;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_guard_trip;
		@(posedge clk) disable iff (rst)
			(active_r && tick && !wr_ctrl && ctrl_r[GUARD_BIT:0] == 7'h40 && !wdg_reset) |=> wdg_reset;
	endproperty
	a_guard_trip: assert property (p_guard_trip) else $error("no reset on timeout");

	property p_hw_active;
		@(posedge clk) disable iff (rst)
			hw_opt_r |=> active_r;
	endproperty
	a_hw_active: assert property (p_hw_active) else $error("strap did not activate");

	property p_halt_arm;
		@(posedge clk) disable iff (rst)
			(halt_req && act_now && halt_reset_option_r && !wdg_reset) |=> wdg_reset;
	endproperty
	a_halt_arm: assert property (p_halt_arm) else $error("halt gave no reset");

	property p_phase_load;
		@(posedge clk) disable iff (rst)
			$rose(wdg_reset) |-> phase_r == (long_phase_r ? 20'(PHASE_LONG) : 20'(PHASE_SHORT));
	endproperty
	a_phase_load: assert property (p_phase_load) else $error("wrong phase length");

	property p_phase_count;
		@(posedge clk) disable iff (rst)
			(wdg_reset && phase_r != 20'h00001) |=> wdg_reset;
	endproperty
	a_phase_count: assert property (p_phase_count) else $error("phase cut short");

	property p_phase_end;
		@(posedge clk) disable iff (rst)
			(phase_r == 20'h00001) |=> !wdg_reset;
	endproperty
	a_phase_end: assert property (p_phase_end) else $error("phase overran");

	property p_grant_pulse;
		@(posedge clk) disable iff (rst)
			halt_grant |-> $past(halt_req);
	endproperty
	a_grant_pulse: assert property (p_grant_pulse) else $error("grant without halt");

	property p_opts_write;
		@(posedge clk) disable iff (rst)
			(wr && addr == ADDR_OPTIONS) |=> halt_reset_option_r == $past(wdata[0]);
	endproperty
	a_opts_write: assert property (p_opts_write) else $error("option not stored");

	property p_cause_sticky;
		@(posedge clk) disable iff (rst)
			cause_r |=> cause_r;
	endproperty
	a_cause_sticky: assert property (p_cause_sticky) else $error("cause flag lost");

	property p_cause_set;
		@(posedge clk) disable iff (rst)
			$rose(wdg_reset) |-> cause_r;
	endproperty
	a_cause_set: assert property (p_cause_set) else $error("cause not recorded");

	property p_read_count;
		@(posedge clk) disable iff (rst)
			(rd && addr == ADDR_CTRL) |=> rdata[GUARD_BIT:0] == $past(ctrl_r[GUARD_BIT:0]);
	endproperty
	a_read_count: assert property (p_read_count) else $error("count read wrong");

	property p_read_act;
		@(posedge clk) disable iff (rst)
			(rd && addr == ADDR_CTRL) |=> rdata[ACT_BIT] == $past(active_r || hw_opt_r);
	endproperty
	a_read_act: assert property (p_read_act) else $error("activate read wrong");

	property p_hold_count;
		@(posedge clk) disable iff (rst)
			(!tick && !wr_ctrl) |=> $stable(ctrl_r[GUARD_BIT:0]);
	endproperty
	a_hold_count: assert property (p_hold_count) else $error("count moved off tick");

	property p_halt_free;
		@(posedge clk) disable iff (rst)
			(halt_req && !halt_reset_option_r) |=> halt_grant;
	endproperty
	a_halt_free: assert property (p_halt_free) else $error("halt refused with option off");

	c_sw: cover property (@(posedge clk) disable iff (rst) wr_ctrl && !wdata[GUARD_BIT] && wdata[ACT_BIT]);
	c_to: cover property (@(posedge clk) disable iff (rst) tick && active_r && ctrl_r[GUARD_BIT:0] == 7'h40);
	c_hl: cover property (@(posedge clk) disable iff (rst) halt_grant);
	c_lg: cover property (@(posedge clk) disable iff (rst) $rose(wdg_reset) && long_phase_r);
	c_hw: cover property (@(posedge clk) disable iff (rst) hw_opt_r && halt_req);
endmodule : watchdog_downcounter

`default_nettype wire

// >>> tb_watchdog_downcounter.sv
// Self-checking bench for the watchdog downcounter.
// Assumes shortened prescaler and reset phases; rst is driven by the bench only.
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_downcounter;
	import wdg_pkg::*;
	localparam int PS = 16;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       hw_opt = 1'b0;
	logic       halt_req = 1'b0;
	logic [7:0] rdata;
	logic       halt_grant;
	logic       wdg_reset;
	logic [7:0] v;
	logic [7:0] w;
	int         cnt;
	int         n_mismatch = 0;
	int         tests_run = 0;
	always #2.5 clk = ~clk;
	watchdog_downcounter #(.PRESCALE(PS), .PHASE_SHORT(4), .PHASE_LONG(8)) u_dut (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.hw_watchdog_opt(hw_opt), .halt_req(halt_req), .halt_grant(halt_grant), .wdg_reset(wdg_reset));
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task stop_test;
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	task wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task halt;
		@(posedge clk);
		halt_req <= 1'b1;
		@(posedge clk);
		halt_req <= 1'b0;
		#1;
	endtask : halt
	// Counts the whole reset phase, first cycle included
	task pulse;
		#1 cnt = (wdg_reset === 1'b1);
		repeat (20) begin
			@(posedge clk);
			#1 cnt += (wdg_reset === 1'b1);
		end
	endtask : pulse
	initial begin
		#100000;
		n_mismatch++;
		stop_test;
	end
	task t_reset_state;
		rd_reg(ADDR_CTRL);
		chk("active", {7'h00, v[ACT_BIT]}, 8'h00);
		rd_reg(ADDR_OPTIONS);
		chk("options", v, 8'h01);
		rd_reg(2'h3);
		chk("unmapped", v, 8'h00);
	endtask : t_reset_state
	task t_free_count;
		rd_reg(ADDR_CTRL);
		w = v;
		repeat (2 * PS - 2) @(posedge clk);
		rd_reg(ADDR_CTRL);
		chk("count", v, w - 8'h02);
		// Inactive: guard falls during this wait but must not trip
		repeat (70 * PS) @(posedge clk);
		#1 chk("idle_rst", wdg_reset, 8'h00);
		halt;
		chk("grant", halt_grant, 8'h01);
	endtask : t_free_count
	task t_sticky;
		wr_reg(ADDR_CTRL, 8'hC5);
		wr_reg(ADDR_CTRL, 8'h45);
		rd_reg(ADDR_CTRL);
		chk("sticky", {7'h00, v[ACT_BIT]}, 8'h01);
	endtask : t_sticky
	task t_timeout;
		// refresh with guard set, then let it lapse
		wr_reg(ADDR_CTRL, 8'hC5);
		repeat (5 * PS - 1) @(posedge clk);
		#1 chk("early", wdg_reset, 8'h00);
		for (int i = 0; i < PS + 4 && wdg_reset !== 1'b1; i++)
			@(posedge clk) #1;
		chk("timeout", wdg_reset, 8'h01);
	endtask : t_timeout
	task t_sw_reset;
		do_reset;
		wr_reg(ADDR_CTRL, 8'h80);
		pulse;
		chk("short", cnt, 8'h04);
	endtask : t_sw_reset
	task t_long_phase;
		do_reset;
		wr_reg(ADDR_OPTIONS, 8'h03);
		wr_reg(ADDR_CTRL, 8'h80);
		pulse;
		chk("long", cnt, 8'h08);
	endtask : t_long_phase
	task t_halt_modes;
		do_reset;
		wr_reg(ADDR_OPTIONS, 8'h00);
		// refresh just before a plain halt
		wr_reg(ADDR_CTRL, 8'hC5);
		halt;
		chk("halt_ok", {halt_grant, wdg_reset}, 8'h02);
		wr_reg(ADDR_OPTIONS, 8'h01);
		halt;
		chk("halt_rst", {halt_grant, wdg_reset}, 8'h01);
	endtask : t_halt_modes
	task t_hw_option;
		@(posedge clk);
		hw_opt <= 1'b1;
		do_reset;
		rd_reg(ADDR_CTRL);
		chk("hw_active", {7'h00, v[ACT_BIT]}, 8'h01);
		halt;
		chk("hw_halt", {halt_grant, wdg_reset}, 8'h01);
		rd_reg(ADDR_STATUS);
		chk("status", v, 8'h03);
	endtask : t_hw_option
	initial begin
		do_reset;
		t_reset_state;
		t_free_count;
		t_sticky;
		t_timeout;
		t_sw_reset;
		t_long_phase;
		t_halt_modes;
		t_hw_option;
		stop_test;
	end
endmodule : tb_watchdog_downcounter
`default_nettype wire
